// ===== bench/sladg_checker.sv
// Port-level assertions for the stack and address generator
`timescale 1ns/1ns
`default_nettype none
module sladg_checker (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire sladg_pkg::sladg_op_t req_op_i,
  input wire sladg_pkg::sladg_mode_t req_mode_i,
  input wire logic is_move_i,
  input wire logic [12:0] file_addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  input wire logic stack_limit_we_i,
  input wire logic [15:0] stack_limit_data_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic stack_err_o,
  input wire logic access_denied_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [15:0] stack_limit_o
);
  // Taken requests by kind
  logic psh, pop, cll, exc, frd;
  logic [15:0] sp;
  assign sp = stack_pointer_o;
  assign psh = req_valid_i && req_ready_o && req_op_i == sladg_pkg::OP_PUSH;
  assign pop = req_valid_i && req_ready_o && req_op_i == sladg_pkg::OP_POP;
  assign cll = req_valid_i && req_ready_o && req_op_i == sladg_pkg::OP_CALL;
  assign exc = req_valid_i && req_ready_o && req_op_i == sladg_pkg::OP_EXC;
  assign frd = req_valid_i && req_ready_o && req_op_i == sladg_pkg::OP_READ
    && req_mode_i == sladg_pkg::AM_FILE && !is_move_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  push_addr_a: assert property (psh |=> mem_addr_o == $past(sp)
    && mem_wdata_o == $past(wdata_i)) else $error("push address wrong");
  push_step_a: assert property (psh |=> sp == $past(sp) + 16'h0002)
    else $error("push step wrong");
  pop_addr_a: assert property (pop |=>
    mem_addr_o == $past(sp) - 16'h0002
    && sp == $past(sp) - 16'h0002) else $error("pop address wrong");
  at_limit_a: assert property (psh && sp == stack_limit_o
    && sp >= 16'h0800 |=> !stack_err_o) else $error("error at limit");
  over_limit_a: assert property (psh && sp > stack_limit_o
    |=> stack_err_o) else $error("overflow missed");
  under_flow_a: assert property (pop && sp < 16'h0802 |=> stack_err_o)
    else $error("underflow missed");
  call_high_a: assert property (cll |=> !req_ready_o ##1
    mem_wdata_o == {9'h000, $past(pc_i[22:16], 2)}) else $error("call word");
  exc_high_a: assert property (exc |=> ##1 mem_wdata_o ==
    {$past(status_low_byte_i, 2), 1'b0, $past(pc_i[22:16], 2)})
    else $error("exception word wrong");
  limit_lsb_a: assert property (stack_limit_we_i |=> stack_limit_o ==
    {$past(stack_limit_data_i[15:1]), 1'b0}) else $error("limit wrong");
  deny_quiet_a: assert property (access_denied_o |->
    !mem_rd_o && !mem_wr_o) else $error("denied access strobed");
  file_addr_a: assert property (frd |=>
    mem_addr_o == {3'h0, $past(file_addr_i)}) else $error("file address");
  // Main scenarios reached
  cover property (psh && sp == stack_limit_o);
  cover property (exc);
  cover property (access_denied_o);
endmodule : sladg_checker
`default_nettype wire

// ===== bench/tb_sladg_top.sv
// Directed bench for the stack and address generator
`timescale 1ns/1ns
`default_nettype none
module tb_sladg_top;
  logic core_clk_i = 1'b0;
  logic reset_n_i, req_valid_i, lit_wide_i, is_move_i, wr_we_i, res_we_i;
  logic res_to_dflt_i, stack_limit_we_i, bs_ram_en_i, exec_boot_i;
  logic ss_ram_en_i, exec_secure_i;
  sladg_pkg::sladg_op_t req_op_i;
  sladg_pkg::sladg_mode_t req_mode_i;
  logic [3:0] ptr_sel_i, base_sel_i, wr_idx_i;
  logic [12:0] file_addr_i;
  logic [22:0] pc_i;
  logic [7:0] status_low_byte_i;
  logic [15:0] lit_i, wdata_i, wr_data_i, res_data_i, stack_limit_data_i;
  logic [15:0] bs_ram_lo_i, bs_ram_hi_i, ss_ram_lo_i, ss_ram_hi_i;
  logic req_ready_o, mem_rd_o, mem_wr_o, op_valid_o, stack_err_o;
  logic access_denied_o;
  logic [15:0] mem_addr_o, mem_wdata_o, op1_data_o, op2_data_o;
  logic [15:0] stack_pointer_o, stack_limit_o;
  int n_fail = 0;
  int n_compared = 0;
  sladg_top sladg_top_i (.*);
  // Free-running core clock
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Register or limit write; one strobe cycle
  task automatic default_working_register(input logic lim, input logic [3:0] idx,
    input logic [15:0] val);
    @(negedge core_clk_i);
    stack_limit_we_i = lim;
    wr_we_i = !lim;
    wr_idx_i = idx;
    wr_data_i = val;
    stack_limit_data_i = val;
    @(negedge core_clk_i);
    stack_limit_we_i = 1'b0;
    wr_we_i = 1'b0;
  endtask : default_working_register
  // One request; returns with the answer cycle on the outputs
  task automatic issue(input sladg_pkg::sladg_op_t op,
    input sladg_pkg::sladg_mode_t md, input logic [3:0] ptr,
    input logic [15:0] lit);
    int i;
    i = 0;
    @(negedge core_clk_i);
    while (req_ready_o !== 1'b1 && i < 20)
    begin
      @(negedge core_clk_i);
      i++;
    end
    // A ready that never comes is a failure, though the run goes on
    if (req_ready_o !== 1'b1)
      n_fail++;
    req_op_i = op;
    req_mode_i = md;
    ptr_sel_i = ptr;
    lit_i = lit;
    req_valid_i = 1'b1;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
  endtask : issue
  task automatic rd(input sladg_pkg::sladg_mode_t md, input logic [3:0] ptr,
    input logic [15:0] lit, input logic [15:0] exp);
    issue(sladg_pkg::OP_READ, md, ptr, lit);
    chk(mem_addr_o, exp);
    chk({15'h0, mem_rd_o & op_valid_o}, 16'h0001);
  endtask : rd
  // Pushes through the limit, then pops into the register area
  task automatic t_stack;
    logic [15:0] s;
    default_working_register(1'b1, 4'h0, 16'h0805); // Next request is a push
    chk(stack_limit_o, 16'h0804);
    chk(stack_pointer_o, 16'h0800);
    for (int k = 0; k < 4; k++)
    begin
      s = stack_pointer_o;
      wdata_i = s ^ 16'hc0de;
      issue(sladg_pkg::OP_PUSH, sladg_pkg::AM_IND, 4'hf, 16'h0000);
      chk(mem_addr_o, s);
      chk(mem_wdata_o, s ^ 16'hc0de);
      chk({15'h0, mem_wr_o}, 16'h0001);
      chk({15'h0, stack_err_o}, {15'h0, s > 16'h0804});
      chk(stack_pointer_o, s + 16'h0002);
    end
    for (int k = 0; k < 5; k++)
    begin
      s = stack_pointer_o - 16'h0002;
      issue(sladg_pkg::OP_POP, sladg_pkg::AM_IND, 4'hf, 16'h0000);
      chk(mem_addr_o, s);
      chk(stack_pointer_o, s);
      chk({15'h0, stack_err_o}, {15'h0, s > 16'h0804 || s < 16'h0800});
    end
  endtask : t_stack
  // Call and exception pushes of the program counter
  task automatic t_call;
    default_working_register(1'b1, 4'h0, 16'h0ffe);
    status_low_byte_i = 8'ha5;
    pc_i = 23'h7abcde;
    for (int k = 0; k < 2; k++)
    begin
      default_working_register(1'b0, 4'hf, 16'h0900);
      issue(k == 0 ? sladg_pkg::OP_CALL : sladg_pkg::OP_EXC,
        sladg_pkg::AM_IND, 4'hf, 16'h0000);
      chk(mem_addr_o, 16'h0900);
      chk(mem_wdata_o, 16'hbcde);
      chk({15'h0, req_ready_o}, 16'h0000);
      @(negedge core_clk_i);
      chk(mem_addr_o, 16'h0902);
      chk(mem_wdata_o, k == 0 ? 16'h007a : 16'ha57a);
      chk(stack_pointer_o, 16'h0904);
    end
    // Indirect write through the stack pointer is range checked too
    wdata_i = 16'h600d;
    issue(sladg_pkg::OP_WRITE, sladg_pkg::AM_PRE, 4'hf, 16'h0800);
    chk(mem_addr_o, 16'h1104);
    chk({mem_wr_o, mem_wdata_o[14:0]}, 16'he00d);
    chk({15'h0, stack_err_o}, 16'h0001);
    chk(stack_pointer_o, 16'h1104);
  endtask : t_call
  // Operand addressing modes, back to back on one pointer
  task automatic t_modes;
    default_working_register(1'b0, 4'h3, 16'h1000);
    default_working_register(1'b0, 4'h4, 16'h0010);
    base_sel_i = 4'h4;
    rd(sladg_pkg::AM_IND, 4'h3, 16'h0000, 16'h1000);
    rd(sladg_pkg::AM_POST, 4'h3, 16'h0002, 16'h1000);
    rd(sladg_pkg::AM_IND, 4'h3, 16'h0000, 16'h1002);
    rd(sladg_pkg::AM_PRE, 4'h3, 16'hfffc, 16'h0ffe);
    rd(sladg_pkg::AM_IND, 4'h3, 16'h0000, 16'h0ffe);
    rd(sladg_pkg::AM_REG_OFF, 4'h3, 16'h0000, 16'h100e);
    rd(sladg_pkg::AM_LIT_OFF, 4'h3, 16'h0020, 16'h101e);
    rd(sladg_pkg::AM_IND, 4'h3, 16'h0000, 16'h0ffe);
    file_addr_i = 13'h1fff;
    rd(sladg_pkg::AM_FILE, 4'h3, 16'hc000, 16'h1fff);
    is_move_i = 1'b1;
    rd(sladg_pkg::AM_FILE, 4'h3, 16'hc000, 16'hc000);
    is_move_i = 1'b0;
    issue(sladg_pkg::OP_READ, sladg_pkg::AM_REG, 4'h3, 16'h0000);
    chk(op2_data_o, 16'h0ffe);
    chk(op1_data_o, 16'h0010);
    chk({15'h0, mem_rd_o}, 16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      lit_wide_i = k[0];
      issue(sladg_pkg::OP_READ, sladg_pkg::AM_LIT, 4'h3, 16'hffff);
      chk(op2_data_o, k == 0 ? 16'h001f : 16'h03ff);
    end
  endtask : t_modes
  // File results to memory and to register zero
  task automatic t_result;
    file_addr_i = 13'h0123;
    rd(sladg_pkg::AM_FILE, 4'h3, 16'h0000, 16'h0123);
    res_data_i = 16'h5a5a;
    res_we_i = 1'b1;
    @(negedge core_clk_i);
    res_we_i = 1'b0;
    chk(mem_addr_o, 16'h0123);
    chk({mem_wr_o, mem_wdata_o[14:0]}, 16'hda5a);
    @(negedge core_clk_i);
    res_to_dflt_i = 1'b1;
    res_data_i = 16'h1234;
    res_we_i = 1'b1;
    @(negedge core_clk_i);
    res_we_i = 1'b0;
    issue(sladg_pkg::OP_READ, sladg_pkg::AM_REG, 4'h0, 16'h0000);
    chk(op2_data_o, 16'h1234);
  endtask : t_result
  // Both secure windows, foreign code then owning code
  task automatic t_secure;
    for (int k = 0; k < 4; k++)
    begin
      bs_ram_en_i = (k < 2);
      ss_ram_en_i = (k >= 2);
      exec_boot_i = k[0];
      exec_secure_i = k[0];
      file_addr_i = k < 2 ? 13'h1010 : 13'h1110;
      issue(sladg_pkg::OP_READ, sladg_pkg::AM_FILE, 4'h3, 16'h0000);
      chk(mem_addr_o, {3'h0, file_addr_i});
      chk({15'h0, mem_rd_o}, {15'h0, k[0]});
      chk({15'h0, access_denied_o}, {15'h0, !k[0]});
    end
  endtask : t_secure
  // Main sequence; window bounds are the only tied inputs
  initial
  begin
    {reset_n_i, req_valid_i, lit_wide_i, is_move_i, wr_we_i, res_we_i,
      res_to_dflt_i, stack_limit_we_i, bs_ram_en_i, exec_boot_i, ss_ram_en_i,
      exec_secure_i, ptr_sel_i, base_sel_i, wr_idx_i, file_addr_i, pc_i,
      status_low_byte_i, lit_i, wdata_i, wr_data_i, res_data_i,
      stack_limit_data_i} = '0;
    req_op_i = sladg_pkg::OP_NONE;
    req_mode_i = sladg_pkg::AM_FILE;
    {bs_ram_lo_i, bs_ram_hi_i} = {16'h1000, 16'h10ff};
    {ss_ram_lo_i, ss_ram_hi_i} = {16'h1100, 16'h11ff};
    repeat (6) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    t_stack;
    t_call;
    t_modes;
    t_result;
    t_secure;
    give_verdict;
  end
  // Run needs under a hundred cycles; far longer means a hang
  initial
  begin
    #100000;
    n_fail++;
    give_verdict;
  end
endmodule : tb_sladg_top
bind sladg_top sladg_checker sladg_checker_i (.*);
`default_nettype wire

// ===== hw/sladg_ea_calc.sv
// Effective address adder for the fundamental operand modes
`timescale 1ns/1ns
`default_nettype none
module sladg_ea_calc (
  sladg_ea_if.calc ea_if
);
  // Direct address: near field, or full literal for a move
  wire [15:0] file_ea;
  assign file_ea = ea_if.is_move ? ea_if.lit :
                   {3'h0, ea_if.file_addr};

  // Shared adder for pre, post and literal offset; step is signed
  wire [15:0] lit_sum;
  assign lit_sum = ea_if.ptr_val + ea_if.lit;

  // Pointer plus base register
  wire [15:0] reg_sum;
  assign reg_sum = ea_if.ptr_val + ea_if.base_val;

  // Short literal, zero extended from either width
  assign ea_if.op2_lit = ea_if.lit_wide ?
    {6'h00, ea_if.lit[sladg_pkg::LONG_LIT_W-1:0]} :
    {11'h000, ea_if.lit[sladg_pkg::SHORT_LIT_W-1:0]};

  // Mode decode
  wire m_post;
  wire m_pre;
  wire m_off;
  wire m_lit_off;
  assign m_post = ea_if.mode == sladg_pkg::AM_POST;
  assign m_pre = ea_if.mode == sladg_pkg::AM_PRE;
  assign m_off = ea_if.mode == sladg_pkg::AM_REG_OFF;
  assign m_lit_off = ea_if.mode == sladg_pkg::AM_LIT_OFF;

  // Address selection; post-modify uses the old pointer
  assign ea_if.ea = (ea_if.mode == sladg_pkg::AM_FILE) ? file_ea :
                    m_pre ? lit_sum :
                    m_lit_off ? lit_sum :
                    m_off ? reg_sum :
                    ea_if.ptr_val;

  // Only pre and post modes write the pointer back
  assign ea_if.ptr_upd = m_post | m_pre;
  assign ea_if.ptr_new = lit_sum;

  // Register direct and literal operands touch no memory
  assign ea_if.is_mem = (ea_if.mode != sladg_pkg::AM_REG) &&
                        (ea_if.mode != sladg_pkg::AM_LIT);
endmodule : sladg_ea_calc
`default_nettype wire

// ===== hw/sladg_top.sv
// Stack pointer, stack limit checks, secure RAM gating and operand addressing
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Stack pointer marks first free word, grows up
// - Push writes then increments; pop decrements then reads
// - Call push clears top nine bits of high word
// - Exception push puts status byte in high word
// - Limit register unreset, bit zero always zero
// - Stack pointer addresses compared against limit register
// - Push at limit passes, next push traps
// - Stack address below 0x0800 traps as underflow
// - Boot secure RAM only for boot code
// - Secure segment RAM only for secure code
// - File direct address is 13 bits, near space
// - File results go to register zero or file
// - Move reaches the whole data space
// - First operand base register, second register/memory/literal
// - Direct, indirect, pre, post, short literal modes
// - File direct address taken from instruction word
// - Post-modify: use pointer, then step it
// - Pre-modify: step pointer, use new value
// - Register offset: pointer plus base register
// - Literal offset: pointer plus instruction literal
module sladg_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire sladg_pkg::sladg_op_t req_op_i,
  input wire sladg_pkg::sladg_mode_t req_mode_i,
  input wire logic [3:0] ptr_sel_i,
  input wire logic [3:0] base_sel_i,
  input wire logic [15:0] lit_i,
  input wire logic lit_wide_i,
  input wire logic [12:0] file_addr_i,
  input wire logic is_move_i,
  input wire logic [15:0] wdata_i,
  input wire logic [22:0] pc_i,
  input wire logic [7:0] status_low_byte_i,
  input wire logic wr_we_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic res_we_i,
  input wire logic res_to_dflt_i,
  input wire logic [15:0] res_data_i,
  input wire logic stack_limit_we_i,
  input wire logic [15:0] stack_limit_data_i,
  input wire logic bs_ram_en_i,
  input wire logic [15:0] bs_ram_lo_i,
  input wire logic [15:0] bs_ram_hi_i,
  input wire logic exec_boot_i,
  input wire logic ss_ram_en_i,
  input wire logic [15:0] ss_ram_lo_i,
  input wire logic [15:0] ss_ram_hi_i,
  input wire logic exec_secure_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [15:0] mem_wdata_o,
  output logic op_valid_o,
  output logic [15:0] op1_data_o,
  output logic [15:0] op2_data_o,
  output logic stack_err_o,
  output logic access_denied_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] stack_limit_o
);
  // One-hot register select, used for pointer and writer ports
  function automatic logic [15:0] sladg_dec(input logic [3:0] idx);
    sladg_dec = 16'h0001 << idx;
  endfunction : sladg_dec

  // Over the limit or into the special register area
  function automatic logic sladg_stk_fault(input logic [15:0] ea,
                                           input logic [15:0] lim);
    sladg_stk_fault = (ea > lim) ||
                      (ea < sladg_pkg::SFR_TOP);
  endfunction : sladg_stk_fault

  // Inclusive address window test for both secure segments
  function automatic logic sladg_in_win(input logic [15:0] a,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    sladg_in_win = (a >= lo) && (a <= hi);
  endfunction : sladg_in_win

  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [15:0] regs_q [sladg_pkg::NREG];
  logic [15:0] regs_d [sladg_pkg::NREG];
  logic [15:0] stack_limit_q;
  logic [15:0] pc_hi_q;
  logic [15:0] res_addr_q;
  sladg_pkg::sladg_state_t state_q;
  sladg_pkg::sladg_state_t state_d;

  // Address adder sits in its own module behind the interface
  sladg_ea_if ea_if ();
  sladg_ea_calc sladg_ea_calc_i (
    .ea_if(ea_if)
  );
  assign ea_if.mode = req_mode_i;
  assign ea_if.is_move = is_move_i;
  assign ea_if.lit_wide = lit_wide_i;
  assign ea_if.file_addr = file_addr_i;
  assign ea_if.lit = lit_i;
  assign ea_if.ptr_val = regs_q[ptr_sel_i];
  assign ea_if.base_val = regs_q[base_sel_i];

  // Request decode
  wire hi_phase, take, op_push, op_pop, op_pc, op_stack, op_rw;
  assign hi_phase = state_q == sladg_pkg::ST_PC_HI;
  // Result write-back owns the memory port, so new requests wait
  assign req_ready_o = (state_q == sladg_pkg::ST_IDLE) && !res_we_i;
  assign take = req_valid_i && req_ready_o;
  assign op_pc = (req_op_i == sladg_pkg::OP_CALL) ||
                 (req_op_i == sladg_pkg::OP_EXC);
  assign op_push = (req_op_i == sladg_pkg::OP_PUSH) || op_pc;
  assign op_pop = req_op_i == sladg_pkg::OP_POP;
  assign op_stack = op_push || op_pop;
  assign op_rw = (req_op_i == sladg_pkg::OP_READ) ||
                 (req_op_i == sladg_pkg::OP_WRITE);

  // Stack pointer arithmetic; pointer always names a free word
  wire [15:0] sp;
  wire [15:0] sp_inc;
  wire [15:0] sp_dec;
  assign sp = regs_q[sladg_pkg::SP_IDX];
  assign sp_inc = sp + sladg_pkg::STACK_STEP;
  assign sp_dec = sp - sladg_pkg::STACK_STEP;

  // Address of this cycle: push at pointer, pop one below it
  wire [15:0] cur_ea;
  assign cur_ea = hi_phase ? sp :
                  (op_stack && op_pop) ? sp_dec :
                  op_stack ? sp :
                  ea_if.ea;

  // Memory access of this cycle
  wire mem_req;
  wire mem_is_wr;
  wire res_mem;
  assign mem_req = hi_phase ||
                   (take && (op_stack || (op_rw && ea_if.is_mem)));
  assign mem_is_wr = hi_phase || op_push ||
                     (req_op_i == sladg_pkg::OP_WRITE);
  // File results bypass memory when aimed at register zero
  assign res_mem = res_we_i && !res_to_dflt_i;

  // Any indirect use of the stack pointer is range checked
  wire sp_used;
  assign sp_used = hi_phase ||
                   (take && (op_stack ||
                   (op_rw && ea_if.is_mem &&
                   (req_mode_i != sladg_pkg::AM_FILE) &&
                   (ptr_sel_i == sladg_pkg::SP_IDX))));

  // Compare uses the limit as stored, so a new limit counts next cycle
  wire stk_err_d;
  assign stk_err_d = sp_used &&
                     sladg_stk_fault(cur_ea, stack_limit_q);

  // Secure segments: deny unless running from the owning flash
  wire [15:0] acc_addr;
  wire bs_deny, ss_deny, deny_d;
  assign acc_addr = res_mem ? res_addr_q : cur_ea;
  assign bs_deny = bs_ram_en_i && !exec_boot_i &&
                   sladg_in_win(acc_addr, bs_ram_lo_i, bs_ram_hi_i);
  assign ss_deny = ss_ram_en_i && !exec_secure_i &&
                   sladg_in_win(acc_addr, ss_ram_lo_i, ss_ram_hi_i);
  assign deny_d = (mem_req || res_mem) && (bs_deny || ss_deny);

  // Strobes: a denied access keeps both strobes low
  wire mem_wr_d;
  wire mem_rd_d;
  wire [15:0] mem_wdata_d;
  assign mem_wr_d = !deny_d && ((mem_req && mem_is_wr) || res_mem);
  assign mem_rd_d = !deny_d && mem_req && !mem_is_wr;
  // Low word of the program counter goes first, high word next
  assign mem_wdata_d = hi_phase ? pc_hi_q :
                       res_mem ? res_data_i :
                       op_pc ? pc_i[15:0] :
                       wdata_i;

  // High stacked word: zeroed top for calls, status byte for traps
  wire [15:0] pc_hi_d;
  assign pc_hi_d = (req_op_i == sladg_pkg::OP_EXC) ?
    {status_low_byte_i, 1'b0, pc_i[sladg_pkg::PC_W-1:16]} :
    {9'h000, pc_i[sladg_pkg::PC_W-1:16]};

  // Pointer write-back from stack ops or pre/post modify
  wire upd_en;
  wire [3:0] upd_idx;
  wire [15:0] upd_val, upd_hit, wr_hit, res_hit;
  assign upd_en = hi_phase || (take && op_stack) ||
                  (take && op_rw && ea_if.ptr_upd);
  assign upd_idx = (hi_phase || op_stack) ? sladg_pkg::SP_IDX : ptr_sel_i;
  assign upd_val = (hi_phase || op_push) ? sp_inc :
                   op_stack ? sp_dec : ea_if.ptr_new;
  assign upd_hit = sladg_dec(upd_idx) & {16{upd_en}};
  assign wr_hit = sladg_dec(wr_idx_i) & {16{wr_we_i}};
  assign res_hit = sladg_dec(sladg_pkg::DFLT_IDX) &
                   {16{res_we_i && res_to_dflt_i}};

  // Register file: address updates win over data writers
  genvar gi;
  generate
    for (gi = 0; gi < sladg_pkg::NREG; gi++)
    begin : g_reg
      localparam logic [15:0] RV = (gi == sladg_pkg::NREG - 1) ?
                                   sladg_pkg::SP_RST : sladg_pkg::REG_RST;
      assign regs_d[gi] = upd_hit[gi] ? upd_val :
                          res_hit[gi] ? res_data_i :
                          wr_hit[gi] ? wr_data_i : regs_q[gi];
      always_ff @(posedge core_clk_i or negedge rst_n_q)
      begin
        if (!rst_n_q)
          regs_q[gi] <= RV;
        else
          regs_q[gi] <= regs_d[gi];
      end
    end
  endgenerate

  // Limit register has no reset; bit zero stored as zero
  always_ff @(posedge core_clk_i)
  begin
    if (stack_limit_we_i)
      stack_limit_q <= {stack_limit_data_i[15:1], 1'b0};
  end

  // Sequencer: a program counter push takes two cycles
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sladg_pkg::ST_IDLE:
      begin
        if (take && op_pc)
          state_d = sladg_pkg::ST_PC_HI;
      end
      sladg_pkg::ST_PC_HI:
        state_d = sladg_pkg::ST_IDLE;
      default:
        state_d = sladg_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state, high push word and file result address
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= sladg_pkg::ST_IDLE;
      pc_hi_q <= sladg_pkg::OUT_RST;
      res_addr_q <= sladg_pkg::OUT_RST;
    end
    else
    begin
      state_q <= state_d;
      if (take && op_pc)
        pc_hi_q <= pc_hi_d;
      if (take && (req_mode_i == sladg_pkg::AM_FILE))
        res_addr_q <= ea_if.ea;
    end
  end

  // Operands: base register direct, second by mode
  wire [15:0] op2_d;
  assign op2_d = (req_mode_i == sladg_pkg::AM_REG) ? regs_q[ptr_sel_i] :
                 (req_mode_i == sladg_pkg::AM_LIT) ? ea_if.op2_lit :
                 sladg_pkg::OUT_RST;

  // Registered bus and status outputs; error rides with its address
  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mem_addr_o <= sladg_pkg::OUT_RST;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= sladg_pkg::OUT_RST;
      stack_err_o <= 1'b0;
      access_denied_o <= 1'b0;
    end
    else
    begin
      mem_addr_o <= acc_addr;
      mem_rd_o <= mem_rd_d;
      mem_wr_o <= mem_wr_d;
      mem_wdata_o <= mem_wdata_d;
      stack_err_o <= stk_err_d;
      access_denied_o <= deny_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      op_valid_o <= 1'b0;
      op1_data_o <= sladg_pkg::OUT_RST;
      op2_data_o <= sladg_pkg::OUT_RST;
    end
    else
    begin
      op_valid_o <= take && op_rw;
      op1_data_o <= regs_q[base_sel_i];
      op2_data_o <= op2_d;
    end
  end

  // Visibility of pointer and limit for the core
  assign stack_pointer_o = sp;
  assign stack_limit_o = stack_limit_q;
endmodule : sladg_top
`default_nettype wire

// ===== pkg/sladg_ea_if.sv
// Operand fields and computed addresses between top and address adder
`timescale 1ns/1ns
`default_nettype none
interface sladg_ea_if;
  sladg_pkg::sladg_mode_t mode;
  logic is_move;
  logic lit_wide;
  logic [12:0] file_addr;
  logic [15:0] lit;
  logic [15:0] ptr_val;
  logic [15:0] base_val;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic ptr_upd;
  logic is_mem;
  logic [15:0] op2_lit;
  modport calc (
    input mode, is_move, lit_wide, file_addr, lit, ptr_val, base_val,
    output ea, ptr_new, ptr_upd, is_mem, op2_lit
  );
  modport user (
    output mode, is_move, lit_wide, file_addr, lit, ptr_val, base_val,
    input ea, ptr_new, ptr_upd, is_mem, op2_lit
  );
endinterface : sladg_ea_if
`default_nettype wire

// ===== pkg/sladg_pkg.sv
// Constants and types shared by the stack and address generator
`default_nettype none
package sladg_pkg;
  // Data path and register file shape
  localparam int unsigned DW = 16;
  localparam int unsigned NREG = 16;
  localparam int unsigned FILE_AW = 13;
  localparam int unsigned PC_W = 23;
  localparam int unsigned PC_HI_W = 7;
  localparam int unsigned SLB_W = 8;
  localparam int unsigned SHORT_LIT_W = 5;
  localparam int unsigned LONG_LIT_W = 10;
  // Register indices with a fixed role
  localparam logic [3:0] SP_IDX = 4'hf;
  localparam logic [3:0] DFLT_IDX = 4'h0;
  // Address constants
  localparam logic [15:0] SFR_TOP = 16'h0800;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // Values after reset
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0800;
  localparam logic [15:0] OUT_RST = 16'h0000;
  // Operand addressing modes
  typedef enum logic [2:0] {
    AM_FILE = 3'h0,
    AM_REG = 3'h1,
    AM_IND = 3'h2,
    AM_POST = 3'h3,
    AM_PRE = 3'h4,
    AM_REG_OFF = 3'h5,
    AM_LIT_OFF = 3'h6,
    AM_LIT = 3'h7
  } sladg_mode_t;
  // Requested operations
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_PUSH = 3'h3,
    OP_POP = 3'h4,
    OP_CALL = 3'h5,
    OP_EXC = 3'h6
  } sladg_op_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_PC_HI = 2'b10
  } sladg_state_t;
endpackage : sladg_pkg
`default_nettype wire
